//--- design/rdcab_device.sv
// rdcab_device: converter end, serial slave plus alarm/status registers
// assumes: sclk and cs_n come from the host; clk runs much faster than sclk
`timescale 1ns/1ns
module rdcab_device (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial link, clocked by the host's sclk
  rdcab_link_if.dev link,
  // detector inputs, asynchronous levels
  input wire logic amp_a_out_of_range,
  input wire logic amp_b_out_of_range,
  input wire logic overtemp_detect,
  // controls to the analog side
  output logic device_reset,
  output logic alarm_pin_n,
  output logic thermal_comparator_en,
  output logic [2:0] monitor_source_sel,
  output logic monitor_wave_mode
);

  localparam int unsigned S_READY = 0;
  localparam int unsigned S_DONE = 1;
  localparam int unsigned S_AMP_A = 2;
  localparam int unsigned S_AMP_B = 3;
  localparam int unsigned S_TEMP = 4;

  // link side, cleared while cs_n is high
  typedef struct packed {
    logic [4:0] cnt;
    logic ready;
    logic done;
  } rdcab_frame_type;

  // link side, kept across frames so the fast side can read it late
  typedef struct packed {
    logic [15:0] sh;
    logic [7:0] addr;
  } rdcab_hold_type;

  typedef struct packed {
    logic miso;
    logic oe;
  } rdcab_out_type;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] agreed;
    logic soft_rst;
    logic [7:0] amp_mon;
    logic [7:0] status;
    logic [7:0] enable;
    logic [7:0] mon_sel;
    logic [7:0] mon_mode;
    logic [7:0] thermal;
    logic [7:0] rdata;
    logic alarm_n;
  } rdcab_bank_type;

  rdcab_frame_type f;
  rdcab_frame_type next_f;
  rdcab_hold_type h;
  rdcab_hold_type next_h;
  rdcab_out_type o;
  rdcab_out_type next_o;
  rdcab_bank_type r;
  rdcab_bank_type next_r;
  logic rise_ready;
  logic rise_done;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] events;
  logic [7:0] clears;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shift in on rising sclk
  always_comb begin
    next_f = f;
    next_h = h;
    // bits after the sixteenth neither shift nor count again
    if (f.cnt < rdcab_pkg::FRAME_BITS) begin
      next_f.cnt = f.cnt + 5'h01;
      next_h.sh = {h.sh[14:0], link.mosi};
    end
    if (f.cnt == rdcab_pkg::ADDR_DONE_BITS - 5'h01) begin
      next_h.addr = {h.sh[6:0], link.mosi};
      next_f.ready = 1'b1;
    end
    if (f.cnt == rdcab_pkg::FRAME_BITS - 5'h01) begin
      next_f.done = 1'b1;
    end
  end

  // a short frame never raises done, so it is dropped whole
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge link.sclk) begin
    h <= next_h;
  end

  // answer bits leave on falling sclk; rdata settled long before
  always_comb begin
    next_o.oe = 1'b1;
    next_o.miso = 1'b0;
    if (f.cnt >= rdcab_pkg::ADDR_DONE_BITS &&
        f.cnt < rdcab_pkg::FRAME_BITS) begin
      next_o.miso = r.rdata[~f.cnt[2:0]];
    end
  end

  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank on clk
  always_comb begin
    next_r = r;
    next_r.sync1 = {overtemp_detect, amp_b_out_of_range,
                    amp_a_out_of_range, f.done, f.ready};
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    for (int i = 0; i < 5; i++) begin
      if (r.sync2[i] == r.sync3[i]) begin
        next_r.agreed[i] = r.sync3[i];
      end
    end
    rise_ready = next_r.agreed[S_READY] & ~r.agreed[S_READY];
    rise_done = next_r.agreed[S_DONE] & ~r.agreed[S_DONE];
    // hold and address are stable while the handshake level stands
    wr_en = rise_done && h.addr[rdcab_pkg::RW_POS] != rdcab_pkg::RW_READ;
    wdata = h.sh[7:0];

    // live range flags; reserved bits fixed
    next_r.amp_mon = rdcab_pkg::AMP_MONITOR_FIXED;
    next_r.amp_mon[rdcab_pkg::POS_AMP_B] = r.agreed[S_AMP_B];
    next_r.amp_mon[rdcab_pkg::POS_AMP_A] = r.agreed[S_AMP_A];

    // active-low sticky flags; comparator must be running for temp
    events = rdcab_pkg::RESET_ZERO;
    events[rdcab_pkg::POS_AMP_ALARM] =
      r.agreed[S_AMP_A] | r.agreed[S_AMP_B];
    events[rdcab_pkg::POS_OVERTEMP] = r.agreed[S_TEMP] &
      r.thermal[rdcab_pkg::POS_THERMAL_EN];
    clears = rdcab_pkg::RESET_ZERO;
    if (wr_en && h.addr[6:0] == rdcab_pkg::ADDR_ALARM_STATUS) begin
      clears = wdata;
    end
    // event wins over a clear in the same cycle
    next_r.status = ((r.status | clears) & ~events) |
                    rdcab_pkg::STATUS_RESERVED;

    if (wr_en) begin
      case (h.addr[6:0])
        rdcab_pkg::ADDR_SOFT_RESET:
          next_r.soft_rst = wdata[rdcab_pkg::POS_SOFT_RESET];
        rdcab_pkg::ADDR_ALARM_ENABLE:
          next_r.enable = wdata & rdcab_pkg::ENABLE_MASK;
        rdcab_pkg::ADDR_MONITOR_SELECT:
          next_r.mon_sel = wdata & rdcab_pkg::SELECT_MASK;
        rdcab_pkg::ADDR_MONITOR_MODE:
          next_r.mon_mode = wdata & rdcab_pkg::BIT0_MASK;
        rdcab_pkg::ADDR_THERMAL_CTRL:
          next_r.thermal = wdata & rdcab_pkg::BIT0_MASK;
        default: begin
        end
      endcase
    end

    // read image taken once the address is in; unmapped reads zero
    if (rise_ready) begin
      case (h.addr[6:0])
        rdcab_pkg::ADDR_SOFT_RESET: next_r.rdata =
          {7'h00, r.soft_rst};
        rdcab_pkg::ADDR_AMP_MONITOR: next_r.rdata = r.amp_mon;
        rdcab_pkg::ADDR_ALARM_STATUS: next_r.rdata = r.status;
        rdcab_pkg::ADDR_ALARM_ENABLE: next_r.rdata = r.enable;
        rdcab_pkg::ADDR_MONITOR_SELECT: next_r.rdata = r.mon_sel;
        rdcab_pkg::ADDR_MONITOR_MODE: next_r.rdata = r.mon_mode;
        rdcab_pkg::ADDR_THERMAL_CTRL: next_r.rdata = r.thermal;
        default: next_r.rdata = rdcab_pkg::RESET_ZERO;
      endcase
    end

    // soft reset: everything but the link path and the bit itself
    if (r.soft_rst) begin
      next_r.amp_mon = rdcab_pkg::RESET_FLAGS;
      next_r.status = rdcab_pkg::RESET_FLAGS;
      next_r.enable = rdcab_pkg::RESET_ZERO;
      next_r.mon_sel = rdcab_pkg::RESET_ZERO;
      next_r.mon_mode = rdcab_pkg::RESET_ZERO;
      next_r.thermal = rdcab_pkg::RESET_ZERO;
    end

    // only an enabled low flag pulls the pin
    next_r.alarm_n = ~|(~next_r.status & next_r.enable &
                        rdcab_pkg::ENABLE_MASK);

    if (srst) begin
      next_r = '0;
      next_r.amp_mon = rdcab_pkg::RESET_FLAGS;
      next_r.status = rdcab_pkg::RESET_FLAGS;
      next_r.enable = rdcab_pkg::RESET_ZERO;
      next_r.alarm_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.miso = o.miso;
  assign link.miso_oe = o.oe;
  assign device_reset = r.soft_rst;
  assign alarm_pin_n = r.alarm_n;
  assign thermal_comparator_en = r.thermal[rdcab_pkg::POS_THERMAL_EN];
  assign monitor_source_sel = r.mon_sel[2:0];
  assign monitor_wave_mode = r.mon_mode[rdcab_pkg::POS_WAVE_MODE];

endmodule

//--- design/rdcab_pkg.sv
// rdcab_pkg: shared constants of the resolver alarm/status register bank
// assumes: both link ends and the bench use these names, nothing imported
package rdcab_pkg;

  // clocking of the serial link
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned LINK_PERIOD_NS = 125;
  // least half period of the serial clock, rounded up to whole cycles
  localparam int unsigned SCLK_HALF_CYCLES =
    (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam logic [4:0] SCLK_HALF_LAST = 5'(SCLK_HALF_CYCLES - 1);

  // frame layout: rw bit, 7 address bits, 8 data bits, msb first
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_DONE_BITS = 5'h08;
  localparam logic RW_READ = 1'b1;
  localparam int unsigned RW_POS = 7;

  // register offsets
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h06;
  localparam logic [6:0] ADDR_AMP_MONITOR = 7'h0e;
  localparam logic [6:0] ADDR_ALARM_STATUS = 7'h12;
  localparam logic [6:0] ADDR_ALARM_ENABLE = 7'h16;
  localparam logic [6:0] ADDR_MONITOR_SELECT = 7'h20;
  localparam logic [6:0] ADDR_MONITOR_MODE = 7'h28;
  localparam logic [6:0] ADDR_THERMAL_CTRL = 7'h48;

  // field positions
  localparam int unsigned POS_SOFT_RESET = 0;
  localparam int unsigned POS_AMP_B = 3;
  localparam int unsigned POS_AMP_A = 1;
  localparam int unsigned POS_AMP_ALARM = 4;
  localparam int unsigned POS_OVERTEMP = 0;
  localparam int unsigned POS_WAVE_MODE = 0;
  localparam int unsigned POS_THERMAL_EN = 0;

  // values after reset and fixed bit patterns
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_FLAGS = 8'hff;
  localparam logic [7:0] AMP_MONITOR_FIXED = 8'h05;
  localparam logic [7:0] STATUS_RESERVED = 8'hee;
  localparam logic [7:0] ENABLE_MASK = 8'h11;
  localparam logic [7:0] SELECT_MASK = 8'h07;
  localparam logic [7:0] BIT0_MASK = 8'h01;

endpackage

//--- design/rdcab_link_if.sv
// rdcab_link_if: four-wire serial link between host and converter
// assumes: host drives sclk, cs_n, mosi; device drives miso when enabled
`timescale 1ns/1ns
interface rdcab_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // undriven line is taken as low, as by a weak pull-down
  assign miso_line = miso_oe ? miso : 1'b0;

  modport dev (input sclk, input cs_n, input mosi, output miso,
               output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso_line);
endinterface

//--- design/rdcab_host.sv
// rdcab_host: serial master that runs one 16-bit frame per request
// assumes: clk at 250 MHz; sclk is made here by division and driven out
`timescale 1ns/1ns
module rdcab_host (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial link
  rdcab_link_if.host link,
  // request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  // answer side
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);

  typedef enum logic [2:0] {
    RDCAB_IDLE, RDCAB_LEAD, RDCAB_HIGH, RDCAB_LOW, RDCAB_TRAIL, RDCAB_GAP
  } rdcab_host_state_type;

  typedef struct packed {
    rdcab_host_state_type state;
    logic [4:0] div;
    logic [4:0] bits;
    logic [15:0] sh_out;
    logic [7:0] sh_in;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic sync1;
    logic sync2;
    logic sync3;
    logic miso_v;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
  } rdcab_host_reg_type;

  rdcab_host_reg_type r;
  rdcab_host_reg_type next_r;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    tick = (r.div == rdcab_pkg::SCLK_HALF_LAST);
    next_r.rsp_valid = 1'b0;
    // miso is a pin: three flops, accepted once second and third agree
    next_r.sync1 = link.miso_line;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    if (r.sync2 == r.sync3) begin
      next_r.miso_v = r.sync3;
    end
    next_r.div = (tick || r.state == RDCAB_IDLE) ? 5'h00 : r.div + 5'h01;
    case (r.state)
      RDCAB_IDLE: begin
        if (req_valid && r.req_ready) begin
          // rw, address, data: msb first
          next_r.sh_out = {~req_write, req_addr, req_wdata};
          next_r.mosi = ~req_write;
          next_r.cs_n = 1'b0;
          next_r.req_ready = 1'b0;
          next_r.bits = 5'h00;
          next_r.state = RDCAB_LEAD;
        end
      end
      RDCAB_LEAD, RDCAB_LOW: begin
        if (tick) begin
          // rising edge: both ends sample here
          next_r.sclk = 1'b1;
          next_r.sh_in = {r.sh_in[6:0], r.miso_v};
          next_r.state = RDCAB_HIGH;
        end
      end
      RDCAB_HIGH: begin
        if (tick) begin
          next_r.sclk = 1'b0;
          next_r.bits = r.bits + 5'h01;
          next_r.sh_out = {r.sh_out[14:0], 1'b0};
          next_r.mosi = r.sh_out[14];
          // exactly sixteen clocks per frame
          if (r.bits == rdcab_pkg::FRAME_BITS - 5'h01) begin
            next_r.state = RDCAB_TRAIL;
            next_r.mosi = 1'b0;
          end else begin
            next_r.state = RDCAB_LOW;
          end
        end
      end
      RDCAB_TRAIL: begin
        if (tick) begin
          next_r.cs_n = 1'b1;
          next_r.rsp_valid = 1'b1;
          next_r.rsp_rdata = r.sh_in;
          next_r.state = RDCAB_GAP;
        end
      end
      RDCAB_GAP: begin
        if (tick) begin
          next_r.req_ready = 1'b1;
          next_r.state = RDCAB_IDLE;
        end
      end
      default: begin
        next_r.state = RDCAB_IDLE;
      end
    endcase
    if (srst) begin
      next_r = '0;
      next_r.state = RDCAB_IDLE;
      next_r.cs_n = 1'b1;
      next_r.req_ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.mosi;
  assign req_ready = r.req_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_rdata = r.rsp_rdata;

endmodule

//--- testbench/rdcab_link_sva.sv
// rdcab_link_sva: wire-level checks of the serial link between both ends
// assumes: instantiated beside the link; host makes sclk from clk
`timescale 1ns/1ns
module rdcab_link_sva (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  typedef struct packed {
    logic [4:0] high_run;
    logic [4:0] rises;
    logic sclk_q;
  } rdcab_chk_type;
  rdcab_chk_type state;
  rdcab_chk_type next_state;

  ////////////////////////////////////////////////////////////////////////////
  // counters: sclk high run and rises per frame, sampled on clk
  always_comb begin
    next_state = state;
    next_state.sclk_q = sclk;
    next_state.high_run = sclk ? state.high_run + 5'h01 : 5'h00;
    if (cs_n) begin
      next_state.rises = 5'h00;
    end else if (sclk && !state.sclk_q) begin
      next_state.rises = state.rises + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("sclk high outside a frame");
  miso_release_a: assert property (cs_n |-> !miso_oe)
    else $error("miso driven outside a frame");
  miso_quiet_a: assert property (!miso_oe |-> !miso)
    else $error("miso data not low while released");
  mosi_hold_a: assert property (sclk && state.sclk_q |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  half_period_a: assert property (
    $fell(sclk) |-> state.high_run == 5'(rdcab_pkg::SCLK_HALF_CYCLES))
    else $error("sclk high time wrong");
  bit_count_a: assert property (
    $rose(cs_n) |-> state.rises == rdcab_pkg::FRAME_BITS)
    else $error("frame not sixteen sclk rises");
  select_lead_a: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("sclk rose too soon after select");
  select_tail_a: assert property ($rose(cs_n) |-> !$past(sclk, 8))
    else $error("select dropped too soon after sclk");
  miso_step_a: assert property (
    miso_oe && $past(miso_oe) && !$fell(sclk) |-> $stable(miso))
    else $error("miso changed off a falling sclk");
  addr_phase_a: assert property (
    !cs_n && state.rises < 5'h08 |-> !miso_line)
    else $error("miso not zero in command phase");

  // a frame ends, a read returns ones, sclk toggles in frame
  cover property ($rose(cs_n));
  cover property (miso_line);
  cover property ($fell(sclk) && !cs_n);
endmodule

//--- testbench/alarm_status_register_bank_test.sv
// alarm_status_register_bank_test: host and device joined over the link
// assumes: design package compiled first; 250 MHz clk, sync reset
`timescale 1ns/1ns
module alarm_status_register_bank_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic amp_a = 1'b0;
  logic amp_b = 1'b0;
  logic hot = 1'b0;
  logic device_reset;
  logic alarm_pin_n;
  logic thermal_en;
  logic [2:0] mon_sel;
  logic wave_mode;
  int miscompares = 0;
  int comparisons = 0;

  always #2 clk = ~clk;

  rdcab_link_if link ();
  rdcab_host i_rdcab_host (.clk(clk), .srst(srst), .link(link),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  rdcab_device i_rdcab_device (.clk(clk), .srst(srst), .link(link),
    .amp_a_out_of_range(amp_a), .amp_b_out_of_range(amp_b),
    .overtemp_detect(hot), .device_reset(device_reset),
    .alarm_pin_n(alarm_pin_n), .thermal_comparator_en(thermal_en),
    .monitor_source_sel(mon_sel), .monitor_wave_mode(wave_mode));
  rdcab_link_sva i_rdcab_link_sva (.clk(clk), .srst(srst),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .miso_oe(link.miso_oe), .miso_line(link.miso_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one frame; entered and left at a falling edge
  task automatic xfer(input logic rd_n, input logic [6:0] addr,
                      input logic [7:0] data, output logic [7:0] rdata);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    req_write = ~rd_n;
    req_addr = addr;
    req_wdata = data;
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk_pin(rsp_valid, 1'b1);
    rdata = rsp_rdata;
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] r;
    xfer(~rdcab_pkg::RW_READ, addr, data, r);
  endtask

  task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    xfer(rdcab_pkg::RW_READ, addr, 8'h00, r);
    chk_reg(r, exp);
  endtask

  // detectors pass three sync flops; twelve cycles leaves margin
  task automatic settle();
    repeat (12) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    chk_pin(alarm_pin_n, 1'b1);
    chk_pin(device_reset, 1'b0);
    rd(7'h06, 8'h00);
    rd(7'h0e, 8'h05);
    rd(7'h12, 8'hff);
    rd(7'h16, 8'h00);
    rd(7'h20, 8'h00);
    rd(7'h28, 8'h00);
    rd(7'h48, 8'h00);
    rd(7'h7f, 8'h00);
  endtask

  task automatic t_fields();
    wr(7'h16, 8'hff);
    rd(7'h16, 8'h11);
    wr(7'h16, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(7'h20, {5'h00, 3'(i)});
      chk_reg({5'h00, mon_sel}, {5'h00, 3'(i)});
    end
    wr(7'h20, 8'hf8);
    rd(7'h20, 8'h00);
    wr(7'h28, 8'hff);
    chk_pin(wave_mode, 1'b1);
    rd(7'h28, 8'h01);
    wr(7'h28, 8'h00);
    chk_pin(wave_mode, 1'b0);
    // reserved status bits are always written as ones
    wr(7'h12, 8'hee);
    rd(7'h12, 8'hff);
    wr(7'h0e, 8'h00);
    rd(7'h0e, 8'h05);
    wr(7'h7f, 8'hff);
    rd(7'h7f, 8'h00);
  endtask

  // flag latches with the pin masked, then shows once enabled
  task automatic t_amp_alarm();
    amp_a = 1'b1;
    settle();
    rd(7'h0e, 8'h07);
    rd(7'h12, 8'hef);
    chk_pin(alarm_pin_n, 1'b1);
    amp_a = 1'b0;
    settle();
    rd(7'h12, 8'hef);
    wr(7'h12, 8'hee);
    rd(7'h12, 8'hef);
    wr(7'h16, 8'h10);
    chk_pin(alarm_pin_n, 1'b0);
    wr(7'h12, 8'hfe);
    rd(7'h12, 8'hff);
    chk_pin(alarm_pin_n, 1'b1);
    amp_b = 1'b1;
    settle();
    chk_pin(alarm_pin_n, 1'b0);
    rd(7'h0e, 8'h0d);
    rd(7'h12, 8'hef);
    amp_b = 1'b0;
    settle();
    wr(7'h12, 8'hff);
    chk_pin(alarm_pin_n, 1'b1);
  endtask

  task automatic t_overtemp();
    wr(7'h16, 8'h01);
    hot = 1'b1;
    settle();
    rd(7'h12, 8'hff);
    chk_pin(alarm_pin_n, 1'b1);
    hot = 1'b0;
    wr(7'h48, 8'hff);
    chk_pin(thermal_en, 1'b1);
    rd(7'h48, 8'h01);
    hot = 1'b1;
    settle();
    rd(7'h12, 8'hfe);
    chk_pin(alarm_pin_n, 1'b0);
    hot = 1'b0;
    wr(7'h16, 8'h00);
    chk_pin(alarm_pin_n, 1'b1);
    wr(7'h12, 8'hef);
    rd(7'h12, 8'hff);
  endtask

  task automatic t_soft_reset();
    wr(7'h20, 8'h05);
    wr(7'h16, 8'h10);
    wr(7'h06, 8'h01);
    chk_pin(device_reset, 1'b1);
    chk_pin(thermal_en, 1'b0);
    chk_reg({5'h00, mon_sel}, 8'h00);
    rd(7'h06, 8'h01);
    rd(7'h16, 8'h00);
    wr(7'h20, 8'h03);
    rd(7'h20, 8'h00);
    wr(7'h06, 8'h00);
    chk_pin(device_reset, 1'b0);
    wr(7'h20, 8'h03);
    chk_reg({5'h00, mon_sel}, 8'h03);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_reset_values();
    t_fields();
    t_amp_alarm();
    t_overtemp();
    t_soft_reset();
    test_done();
  end

  // about sixty frames of some 550 cycles each are expected
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
